//--- src/wdtc_pkg.sv
// Package for the watchdog timer control block: register map, field
// positions, reset values, unlock signature and vector numbers.
// Assumes a 32-bit Avalon-MM slave with byte addresses and 8-bit registers.
package wdtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;  // watchdog_control_status
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h4;  // reset_cause_status
  localparam logic [3:0] ADDR_CCP         = 4'h8;  // config_change_protect

  ////////////////////////////////////////////////////////////////////////////
  // watchdog_control_status fields
  localparam int BIT_IRQ_FLAG    = 7;
  localparam int BIT_IRQ_ENABLE  = 6;
  localparam int BIT_PERIOD_HI   = 5;
  localparam int BIT_RESERVED    = 4;
  localparam int BIT_RESET_EN    = 3;
  localparam int BIT_PERIOD_LO_H = 2;
  localparam int BIT_PERIOD_LO_L = 0;

  // reset_cause_status field
  localparam int BIT_WD_RESET_FLAG = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [3:0] PERIOD_RESET   = 4'h0;
  localparam logic [3:0] PERIOD_MAX     = 4'h9;   // codes above time out as this
  localparam logic [7:0] UNLOCK_SIG     = 8'hD8;
  localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;   // instruction cycles
  localparam int         CNT_W          = 18;     // 256K oscillator cycles
  localparam logic [4:0] PERIOD_BASE_SH = 5'h09;  // code 0 is 512 cycles

  ////////////////////////////////////////////////////////////////////////////
  // Vectors toward the reset unit and interrupt controller
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  localparam logic [4:0]  TIMEOUT_VECTOR = 5'h04;

  // Action chosen by the two enables
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_IRQ,
    MODE_RESET,
    MODE_IRQ_THEN_RESET
  } wdtc_mode_t;

endpackage : wdtc_pkg

//--- src/wdtc_timeout_counter.sv
// Time-out counter clocked by synchronised oscillator edges.
// Assumes oscEdge is a one-cycle pulse already in the clock domain.
`timescale 1ns/1ps
module wdtc_timeout_counter (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    clkEn,
  // Control
  input  wire logic                    oscEdge,
  input  wire logic                    run,
  input  wire logic                    restart,
  input  wire logic [3:0]              periodCode,
  // Status
  output logic                         expire,
  output logic [wdtc_pkg::CNT_W-1:0]   count
);

  logic [wdtc_pkg::CNT_W:0]   limitWide;
  logic [wdtc_pkg::CNT_W-1:0] limitVal;
  logic [wdtc_pkg::CNT_W-1:0] count_r;
  logic                       expire_r;

  // Terminal count: 512 << code, less one
  always_comb
  begin
    limitWide = (19'(1) << (5'(periodCode) + wdtc_pkg::PERIOD_BASE_SH)) - 19'(1);
    limitVal  = limitWide[wdtc_pkg::CNT_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end
    else if (clkEn)
    begin
      expire_r <= 1'b0;
      if (restart || !run)
        count_r <= '0;
      else if (oscEdge)
      begin
        if (count_r >= limitVal)
        begin
          count_r  <= '0;
          expire_r <= 1'b1;
        end
        else
          count_r <= count_r + 1'b1;
      end
    end
  end

  assign expire = expire_r;
  assign count  = count_r;

  stop_clears_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && (restart || !run) |=> count_r == '0 && !expire_r)
    else $error("counter not restarted");

endmodule : wdtc_timeout_counter

//--- src/wdtc_watchdog_top.sv
// Watchdog timer control and status: control/status register, reset-cause
// flag, timed unlock, safety levels and time-out actions.
// Assumes an Avalon-MM master on clock, a free-running low-power oscillator
// level on oscClk, and a reset unit that pulses rst after sysResetReq.
`timescale 1ns/1ps
module wdtc_watchdog_top (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Processor and system
  input  wire logic        oscClk,
  input  wire logic        refresh,
  input  wire logic        globalIrqEnable,
  input  wire logic        vectorTaken,
  input  wire logic        powerOnReset,
  input  wire logic        alwaysOnFuse,
  // Toward interrupt controller and reset unit
  output logic             timeoutIrqReq,
  output logic [4:0]       timeoutVectorSource,
  output logic             sysResetReq,
  output logic [15:0]      resetVector
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                       ack_r;
  logic [31:0]                readData_r;
  logic                       wrAccept;
  logic                       wrLane0;
  logic                       wrCtl;
  logic                       wrCause;
  logic                       wrCcp;
  logic [7:0]                 wd;
  logic [3:0]                 wrPeriod;
  logic                       levelTwo_r;
  logic [2:0]                 unlockCnt_r;
  logic                       unlocked;
  logic                       irqFlag_r;
  logic                       irqEnable_r;
  logic                       resetEnable_r;
  logic [3:0]                 period_r;
  logic                       wdResetFlag_r;
  logic                       resetEnEff;
  logic [3:0]                 periodEff;
  logic [7:0]                 ctrlRead;
  logic [2:0]                 oscSync_r;
  logic                       oscEdge;
  logic                       expire;
  logic                       run;
  logic                       sysReset_r;
  logic                       irqEvent;
  logic                       resetEvent;
  logic [wdtc_pkg::CNT_W-1:0] count;
  wdtc_pkg::wdtc_mode_t       mode;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer
  assign waitrequest = (read || write) && !ack_r;
  assign wrAccept    = write && ack_r;
  assign wrLane0     = wrAccept && byteenable[0];
  assign wrCtl       = wrLane0 && address == wdtc_pkg::ADDR_CTRL_STATUS;
  assign wrCause     = wrLane0 && address == wdtc_pkg::ADDR_RESET_CAUSE;
  assign wrCcp       = wrLane0 && address == wdtc_pkg::ADDR_CCP;
  assign wd          = writedata[7:0];
  assign wrPeriod    = {wd[wdtc_pkg::BIT_PERIOD_HI],
                        wd[wdtc_pkg::BIT_PERIOD_LO_H:wdtc_pkg::BIT_PERIOD_LO_L]};

  always_ff @(posedge clock)
  begin
    if (rst)
      ack_r <= 1'b0;
    else if (clkEn)
      ack_r <= (read || write) && !ack_r;
  end

  // Read data is captured in the wait cycle so it stands at the answer edge
  always_ff @(posedge clock)
  begin
    if (rst)
      readData_r <= 32'h0000_0000;
    else if (clkEn && read && !ack_r)
    begin
      case (address)
        wdtc_pkg::ADDR_CTRL_STATUS: readData_r <= {24'h00_0000, ctrlRead};
        wdtc_pkg::ADDR_RESET_CAUSE:
          readData_r <= 32'(wdResetFlag_r) << wdtc_pkg::BIT_WD_RESET_FLAG;
        default:                    readData_r <= 32'h0000_0000;
      endcase
    end
  end

  assign readdata = readData_r;

  always_comb
  begin
    ctrlRead                             = 8'h00;
    ctrlRead[wdtc_pkg::BIT_IRQ_FLAG]     = irqFlag_r;
    ctrlRead[wdtc_pkg::BIT_IRQ_ENABLE]   = irqEnable_r;
    ctrlRead[wdtc_pkg::BIT_PERIOD_HI]    = period_r[3];
    ctrlRead[wdtc_pkg::BIT_RESET_EN]     = resetEnEff;
    ctrlRead[wdtc_pkg::BIT_PERIOD_LO_H:wdtc_pkg::BIT_PERIOD_LO_L] = period_r[2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safety level: fuse sampled while reset is held
  always_ff @(posedge clock)
  begin
    if (rst)
      levelTwo_r <= alwaysOnFuse;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timed unlock after the signature write
  always_ff @(posedge clock)
  begin
    if (rst)
      unlockCnt_r <= 3'h0;
    else if (clkEn)
    begin
      if (wrCcp && wd == wdtc_pkg::UNLOCK_SIG)
        unlockCnt_r <= wdtc_pkg::UNLOCK_CYCLES;
      else if (unlockCnt_r != 3'h0)
        unlockCnt_r <= unlockCnt_r - 3'h1;
    end
  end

  assign unlocked = unlockCnt_r != 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Enables, period and effective values
  assign resetEnEff = levelTwo_r || resetEnable_r || wdResetFlag_r;
  // Reserved codes use the longest valid period
  assign periodEff  = (period_r > wdtc_pkg::PERIOD_MAX) ? wdtc_pkg::PERIOD_MAX
                                                        : period_r;
  assign mode       = wdtc_pkg::wdtc_mode_t'({resetEnEff, irqEnable_r});

  always_comb
  begin
    case (mode)
      wdtc_pkg::MODE_STOP:
      begin
        run        = 1'b0;
        irqEvent   = 1'b0;
        resetEvent = 1'b0;
      end
      wdtc_pkg::MODE_IRQ, wdtc_pkg::MODE_IRQ_THEN_RESET:
      begin
        run        = 1'b1;
        irqEvent   = expire;
        resetEvent = 1'b0;
      end
      wdtc_pkg::MODE_RESET:
      begin
        run        = 1'b1;
        irqEvent   = 1'b0;
        resetEvent = expire;
      end
      default:
      begin
        run        = 1'b0;
        irqEvent   = 1'b0;
        resetEvent = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      irqEnable_r <= 1'b0;
    else if (clkEn)
    begin
      if (wrCtl && !levelTwo_r)
        irqEnable_r <= wd[wdtc_pkg::BIT_IRQ_ENABLE];
      else if (levelTwo_r)
        irqEnable_r <= 1'b0;
      else if (irqEvent && resetEnEff)
        irqEnable_r <= 1'b0;
    end
  end

  // Level one enables freely and disables only when unlocked
  always_ff @(posedge clock)
  begin
    if (rst)
      resetEnable_r <= 1'b0;
    else if (clkEn && wrCtl && !levelTwo_r)
    begin
      if (wd[wdtc_pkg::BIT_RESET_EN])
        resetEnable_r <= 1'b1;
      else if (unlocked && !wdResetFlag_r)
        resetEnable_r <= 1'b0;
    end
  end

  // Level one changes period freely, level two only when unlocked
  always_ff @(posedge clock)
  begin
    if (rst)
      period_r <= wdtc_pkg::PERIOD_RESET;
    else if (clkEn && wrCtl && (!levelTwo_r || unlocked))
      period_r <= wrPeriod;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out flag: set wins over both clears
  always_ff @(posedge clock)
  begin
    if (rst)
      irqFlag_r <= 1'b0;
    else if (clkEn)
    begin
      if (irqEvent)
        irqFlag_r <= 1'b1;
      else if (vectorTaken)
        irqFlag_r <= 1'b0;
      else if (wrCtl && wd[wdtc_pkg::BIT_IRQ_FLAG])
        irqFlag_r <= 1'b0;
    end
  end

  assign timeoutIrqReq       = irqFlag_r && irqEnable_r && globalIrqEnable;
  assign timeoutVectorSource = wdtc_pkg::TIMEOUT_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog reset flag survives chip reset, cleared by power-on
  always_ff @(posedge clock)
  begin
    if (powerOnReset)
      wdResetFlag_r <= 1'b0;
    else if (rst)
      wdResetFlag_r <= wdResetFlag_r;
    else if (clkEn)
    begin
      if (resetEvent)
        wdResetFlag_r <= 1'b1;
      else if (wrCause && !wd[wdtc_pkg::BIT_WD_RESET_FLAG])
        wdResetFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      sysReset_r <= 1'b0;
    else if (clkEn)
      sysReset_r <= resetEvent;
  end

  assign sysResetReq = sysReset_r;
  assign resetVector = wdtc_pkg::RESET_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator level crosses in; only stages two and three are compared
  always_ff @(posedge clock)
  begin
    if (rst)
      oscSync_r <= 3'h0;
    else if (clkEn)
      oscSync_r <= {oscSync_r[1:0], oscClk};
  end

  assign oscEdge = oscSync_r[1] && !oscSync_r[2];

  wdtc_timeout_counter u_counter (
    .clock      (clock),
    .rst        (rst),
    .clkEn      (clkEn),
    .oscEdge    (oscEdge),
    .run        (run),
    .restart    (refresh || sysReset_r),
    .periodCode (periodEff),
    .expire     (expire),
    .count      (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  flag_set_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && expire && irqEnable_r |=> irqFlag_r)
    else $error("flag not set on expiry");

  flag_vector_clear_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && vectorTaken && !irqEvent |=> !irqFlag_r)
    else $error("flag not cleared by vector");

  flag_write_clear_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && wrCtl && wd[7] && !irqEvent |=> !irqFlag_r)
    else $error("flag not cleared by write one");

  irq_gate_a: assert property (@(posedge clock) disable iff (rst)
    timeoutIrqReq |-> irqFlag_r && irqEnable_r && globalIrqEnable)
    else $error("request without all enables");

  irq_not_reset_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && expire && irqEnable_r |=> !sysResetReq)
    else $error("reset in interrupt mode");

  enable_auto_clear_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && expire && irqEnable_r && resetEnEff && !wrCtl |=> !irqEnable_r)
    else $error("interrupt enable not cleared");

  stopped_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && !resetEnEff && !irqEnable_r |=> count == '0)
    else $error("counter runs while stopped");

  level_two_a: assert property (@(posedge clock) disable iff (rst)
    levelTwo_r && clkEn |=> !irqEnable_r && ctrlRead[3])
    else $error("level two enables wrong");

  forced_enable_a: assert property (@(posedge clock) disable iff (rst)
    wdResetFlag_r |-> ctrlRead[3])
    else $error("reset enable not forced");

  reserved_bit_a: assert property (@(posedge clock) disable iff (rst)
    read && !waitrequest && address == wdtc_pkg::ADDR_CTRL_STATUS |-> !readdata[4])
    else $error("reserved bit reads one");

  locked_period_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && wrCtl && levelTwo_r && !unlocked |=> $stable(period_r))
    else $error("locked period changed");

  reset_pulse_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && expire && !irqEnable_r && resetEnEff |=> sysResetReq && wdResetFlag_r)
    else $error("watchdog reset missing");

  irq_seen_c: cover property (@(posedge clock) disable iff (rst)
    timeoutIrqReq);
  irq_then_reset_c: cover property (@(posedge clock) disable iff (rst)
    irqEvent && resetEnEff ##[1:1000] resetEvent);
  unlock_write_c: cover property (@(posedge clock) disable iff (rst)
    wrCcp ##[1:4] wrCtl && unlocked);

endmodule : wdtc_watchdog_top

//--- tb/watchdog_timer_control_tb_top.sv
// Self-checking bench for the watchdog timer control block.
// Assumes one wait cycle per bus access and an oscillator that may toggle every clock.
`timescale 1ns/1ps
module watchdog_timer_control_tb_top;

  ////////////////////////////////////////////////////////////////////////////
  logic        clock;
  logic        rst;
  logic        clkEn;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        oscClk;
  logic        refresh;
  logic        globalIrqEnable;
  logic        vectorTaken;
  logic        powerOnReset;
  logic        alwaysOnFuse;
  logic        timeoutIrqReq;
  logic [4:0]  timeoutVectorSource;
  logic        sysResetReq;
  logic [15:0] resetVector;
  int          badCount;
  int          testsRun;
  int          resetCount;
  logic [7:0]  lfsr;

  wdtc_watchdog_top dut (
    .clock(clock), .rst(rst), .clkEn(clkEn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .oscClk(oscClk), .refresh(refresh), .globalIrqEnable(globalIrqEnable),
    .vectorTaken(vectorTaken), .powerOnReset(powerOnReset), .alwaysOnFuse(alwaysOnFuse),
    .timeoutIrqReq(timeoutIrqReq), .timeoutVectorSource(timeoutVectorSource),
    .sysResetReq(sysResetReq), .resetVector(resetVector)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #5 clock = ~clock;

  // One oscillator rising edge every two clocks keeps the time-outs short
  always @(posedge clock) oscClk <= ~oscClk;

  always @(posedge clock)
  begin
    if (sysResetReq === 1'b1)
      resetCount <= resetCount + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext

  function automatic logic [7:0] ctrlVal(input logic f, input logic ie, input logic re,
                                         input logic [3:0] c);
    return {f, ie, c[3], 1'b0, re, c[2:0]};
  endfunction : ctrlVal

  function automatic int expCycles(input logic [3:0] c);
    return (512 << c) * 2;
  endfunction : expCycles

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    testsRun++;
    if (seen !== exp)
    begin
      badCount++;
      $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : endOfTest

  // Holds the request until waitrequest is sampled low, then releases and idles one edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    address   <= a;
    writedata <= {24'h00_0000, d};
    write     <= wr;
    read      <= ~wr;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    q = readdata[7:0];
    if (n >= 20)
      check(32'h0000_0000, 32'h0000_0001, "bus never answered");
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check({24'h00_0000, q}, {24'h00_0000, e}, what);
  endtask : rd

  task automatic pulseRefresh;
    refresh <= 1'b1;
    @(posedge clock);
    refresh <= 1'b0;
  endtask : pulseRefresh

  task automatic doReset(input logic fuse, input logic por);
    rst          <= 1'b1;
    alwaysOnFuse <= fuse;
    powerOnReset <= por;
    repeat (6) @(posedge clock);
    rst          <= 1'b0;
    powerOnReset <= 1'b0;
    @(posedge clock);
  endtask : doReset

  task automatic note(input string s);
    $display("test %s ended, mismatches so far %0d", s, badCount);
  endtask : note

  // Interrupt-mode time-out measured from a second refresh, then flag handling
  task automatic measure(input logic [3:0] c, input logic byVector);
    int n;
    wr(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b0, 1'b1, 1'b0, c));
    pulseRefresh();
    repeat (700) @(posedge clock);
    pulseRefresh();
    n = 0;
    while (timeoutIrqReq !== 1'b1 && n < 2 * expCycles(c))
    begin
      @(posedge clock);
      n++;
    end
    check(32'(n >= expCycles(c) - 4 && n <= expCycles(c) + 8), 32'h0000_0001, "span");
    globalIrqEnable <= 1'b0;
    repeat (2) @(posedge clock);
    check(32'(timeoutIrqReq), 32'h0000_0000, "masked request");
    rd(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b1, 1'b1, 1'b0, c), "flag set");
    wr(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b0, 1'b1, 1'b0, c));
    rd(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b1, 1'b1, 1'b0, c), "zero kept flag");
    if (byVector)
    begin
      vectorTaken <= 1'b1;
      @(posedge clock);
      vectorTaken <= 1'b0;
    end
    else
      wr(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b1, 1'b1, 1'b0, c));
    rd(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b0, 1'b1, 1'b0, c), "flag cleared");
    globalIrqEnable <= 1'b1;
    @(posedge clock);
  endtask : measure

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge clock);
    badCount++;
    $display("BAD %0t run did not finish in time", $time);
    endOfTest();
  end

  initial
  begin
    int         n;
    logic [3:0] c;
    logic [7:0] q;
    clock = 1'b0; rst = 1'b1; clkEn = 1'b1; address = 4'h0; read = 1'b0; write = 1'b0;
    writedata = 32'h0000_0000; byteenable = 4'hF; oscClk = 1'b0; refresh = 1'b0;
    globalIrqEnable = 1'b1; vectorTaken = 1'b0; powerOnReset = 1'b1; alwaysOnFuse = 1'b0;
    badCount = 0; testsRun = 0; resetCount = 0; lfsr = 8'h60;
    doReset(1'b0, 1'b1);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00, "ctrl after reset");
    rd(wdtc_pkg::ADDR_RESET_CAUSE, 8'h00, "cause after power-on");
    rd(wdtc_pkg::ADDR_CCP, 8'h00, "protect reads zero");
    wr(4'hC, 8'hFF);
    rd(4'hC, 8'h00, "unmapped read");
    repeat (2500) @(posedge clock);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00, "stopped no flag");
    check(32'(resetCount), 32'h0000_0000, "stopped no reset");
    note("reset and stop");
    // Reserved period codes read back as written; the reserved bit never does
    for (int i = 0; i < 3; i++)
    begin
      lfsr = lfsrNext(lfsr);
      c = 4'hA + 4'(lfsr % 6);
      wr(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b0, 1'b1, 1'b0, c) | 8'h10);
      rd(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b0, 1'b1, 1'b0, c), "reserved bits");
    end
    note("reserved fields");
    for (int i = 0; i < 3; i++)
    begin
      lfsr = lfsrNext(lfsr);
      measure(4'(lfsr % 3), 1'(i));
    end
    check(32'(resetCount), 32'h0000_0000, "interrupt mode no reset");
    note("interrupt mode");
    // Interrupt first, then reset on the following time-out
    wr(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b0, 1'b1, 1'b1, 4'h0));
    pulseRefresh();
    // The enable drops on the same edge the flag rises, so the request never shows: poll the flag
    n = 0;
    q = 8'h00;
    while (q[7] !== 1'b1 && n < 1000)
    begin
      bus(1'b0, wdtc_pkg::ADDR_CTRL_STATUS, 8'h00, q);
      n++;
    end
    rd(wdtc_pkg::ADDR_CTRL_STATUS, ctrlVal(1'b1, 1'b0, 1'b1, 4'h0), "enable auto-cleared");
    check(32'(resetCount), 32'h0000_0000, "interrupt came first");
    n = 0;
    while (resetCount == 0 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    check(32'(resetCount), 32'h0000_0001, "second time-out resets");
    check({16'h0000, resetVector}, 32'h0000_0000, "reset vector");
    check({27'h000_0000, timeoutVectorSource}, 32'h0000_0004, "vector source");
    doReset(1'b0, 1'b0);
    rd(wdtc_pkg::ADDR_RESET_CAUSE, 8'h08, "reset flag set");
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08, "enable forced");
    wr(wdtc_pkg::ADDR_CCP, wdtc_pkg::UNLOCK_SIG);
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08, "flag holds enable");
    wr(wdtc_pkg::ADDR_RESET_CAUSE, 8'h00);
    rd(wdtc_pkg::ADDR_RESET_CAUSE, 8'h00, "zero clears flag");
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08);
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08, "locked disable");
    wr(wdtc_pkg::ADDR_CCP, wdtc_pkg::UNLOCK_SIG);
    repeat (8) @(posedge clock);
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08, "late write refused");
    wr(wdtc_pkg::ADDR_CCP, wdtc_pkg::UNLOCK_SIG);
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00, "unlocked disable");
    note("reset mode and level one");
    // Level two: always enabled, interrupt enable stuck low, period locked
    doReset(1'b1, 1'b1);
    pulseRefresh();
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08, "level two enabled");
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h40);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08, "irq enable ignored");
    wr(wdtc_pkg::ADDR_CCP, wdtc_pkg::UNLOCK_SIG);
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h01);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h09, "unlocked period");
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h02);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h09, "locked period");
    wr(wdtc_pkg::ADDR_CCP, wdtc_pkg::UNLOCK_SIG);
    wr(wdtc_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(wdtc_pkg::ADDR_CTRL_STATUS, 8'h08, "cannot disable");
    n = 0;
    while (resetCount == 1 && n < 4500)
    begin
      @(posedge clock);
      n++;
    end
    check(32'(resetCount), 32'h0000_0002, "level two resets");
    note("level two");
    endOfTest();
  end

endmodule : watchdog_timer_control_tb_top
